// >>> src/azb_cfg.svh
`ifndef AZB_CFG_SVH
`define AZB_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define AZB_CLK_NS 8
`define AZB_FAST_PERIOD_NS 1100000
`define AZB_NORM_PERIOD_CYC 1000000
`define AZB_FAST_PERIODS 2'h3

// ----------------------------------------
// Transition thresholds
// ----------------------------------------
`define AZB_BASE_PERIODS 6'h03
`define AZB_DELAY_BASE 6'h06
`define AZB_CNT_MAX 6'h3F

// ----------------------------------------
// Fall hold register
// ----------------------------------------
`define AZB_HOLD_RST 8'h00
`define AZB_HOLD_CODE_LSB 0
`define AZB_HOLD_CODE_MSB 4

// ----------------------------------------
// Zones
// ----------------------------------------
`define AZB_ZONE0 3'h0

`endif

// >>> src/azb_period_gen.sv
`timescale 1ns/1ps
`include "azb_cfg.svh"

module azb_period_gen
  import azb_pkg::*;
#(
  parameter int FAST_CYC = `AZB_FAST_PERIOD_NS / `AZB_CLK_NS,
  parameter int NORM_CYC = `AZB_NORM_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic als_en,
  // Period ticks
  azb_tick_if.gen tk
);

  localparam int CW = $clog2(((FAST_CYC > NORM_CYC) ? FAST_CYC : NORM_CYC) + 1);

  generate
    if (FAST_CYC < 2 || NORM_CYC < 2)
    begin : g_chk
      $error("azb_period_gen: period counts must be at least 2");
    end
  endgenerate

  // ----------------------------------------
  // Period divider
  // ----------------------------------------
  logic [CW-1:0] cnt_r;
  logic [1:0] fast_left_r;
  logic en_d_r;
  logic tick_r;
  logic fast_r;
  wire start = als_en & ~en_d_r;
  wire [CW-1:0] limit = (fast_left_r != 2'h0) ? CW'(FAST_CYC - 1) : CW'(NORM_CYC - 1);
  wire wrap = (cnt_r == limit);

  always_ff @(posedge mclk)
  begin
    if (sys_rst || !als_en)
    begin
      cnt_r <= '0;
      fast_left_r <= 2'h0;
      en_d_r <= 1'b0;
      tick_r <= 1'b0;
      fast_r <= 1'b0;
    end
    else
    begin
      en_d_r <= 1'b1;
      tick_r <= wrap & ~start;
      if (start)
      begin
        cnt_r <= '0;
        fast_left_r <= `AZB_FAST_PERIODS;
        fast_r <= 1'b1;
      end
      else if (wrap)
      begin
        cnt_r <= '0;
        if (fast_left_r != 2'h0)
        begin
          fast_left_r <= fast_left_r - 2'h1;
        end
        fast_r <= (fast_left_r > 2'h1);
      end
      else
      begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  assign tk.tick = tick_r;
  assign tk.fast = fast_r;

endmodule

// >>> src/azb_pkg.sv
package azb_pkg;

  typedef enum logic [1:0]
  {
    AZB_DIRECT = 2'h0,
    AZB_UP_ONLY = 2'h1,
    AZB_DOWN_DELAY = 2'h2
  } azb_alg_t;

  typedef enum logic [2:0]
  {
    AZB_TR_IDLE = 3'b001,
    AZB_TR_UP = 3'b010,
    AZB_TR_DOWN = 3'b100
  } azb_trend_t;

  typedef logic [2:0] azb_zone_t;

endpackage

// >>> src/azb_tick_if.sv
`timescale 1ns/1ps

interface azb_tick_if;
  logic tick;
  logic fast;

  modport gen
  (
    output tick,
    output fast
  );

  modport use_side
  (
    input tick,
    input fast
  );
endinterface

// >>> src/azb_zone_filter.sv
`timescale 1ns/1ps
`include "azb_cfg.svh"

module azb_zone_filter
  import azb_pkg::*;
#(
  parameter int FAST_CYC = `AZB_FAST_PERIOD_NS / `AZB_CLK_NS,
  parameter int NORM_CYC = `AZB_NORM_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic als_en,
  input wire logic [1:0] light_mapper_one_alg,
  input wire logic [1:0] light_mapper_two_alg,
  input wire logic [1:0] light_mapper_three_alg,
  // Fall hold register
  input wire logic hold_wr,
  input wire logic [7:0] hold_wdata,
  output logic [7:0] light_fall_hold_count,
  // Averager side
  input wire logic [2:0] period_zone,
  output logic period_tick,
  output logic fast_avg,
  output logic [2:0] avg_zone,
  // Current sink side
  output logic [2:0] light_mapper_one_zone,
  output logic [2:0] light_mapper_two_zone,
  output logic [2:0] light_mapper_three_zone,
  output logic [2:0] target_upd
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [5:0] fall_need(input logic [1:0] alg, input logic [4:0] code);
    begin
      if (alg == AZB_DOWN_DELAY)
      begin
        fall_need = `AZB_DELAY_BASE + {1'b0, code};
      end
      else
      begin
        fall_need = `AZB_BASE_PERIODS;
      end
    end
  endfunction

  function automatic logic [5:0] cnt_inc(input logic [5:0] c);
    begin
      cnt_inc = (c == `AZB_CNT_MAX) ? c : c + 6'h01;
    end
  endfunction

  // ----------------------------------------
  // Period generator
  // ----------------------------------------
  azb_tick_if tk ();

  azb_period_gen #(
    .FAST_CYC(FAST_CYC),
    .NORM_CYC(NORM_CYC)
  ) u_gen (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .als_en(als_en),
    .tk(tk)
  );

  // ----------------------------------------
  // Fall hold register
  // ----------------------------------------
  logic [7:0] hold_r;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      hold_r <= `AZB_HOLD_RST;
    end
    else if (hold_wr)
    begin
      hold_r <= hold_wdata;
    end
  end

  wire [4:0] hold_code = hold_r[`AZB_HOLD_CODE_MSB:`AZB_HOLD_CODE_LSB];

  // ----------------------------------------
  // Averager output zone
  // ----------------------------------------
  logic [2:0] zone_r;
  logic tick_d_r;
  logic fast_d_r;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || !als_en)
    begin
      zone_r <= `AZB_ZONE0;
    end
    else if (tk.tick)
    begin
      zone_r <= period_zone;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tick_d_r <= 1'b0;
      fast_d_r <= 1'b0;
    end
    else
    begin
      tick_d_r <= tk.tick;
      fast_d_r <= tk.fast;
    end
  end

  // ----------------------------------------
  // Mapper decision logic
  // ----------------------------------------
  wire [1:0] alg_in [3];
  logic [2:0] tgt_r [3];
  logic upd_r [3];

  assign alg_in[0] = light_mapper_one_alg;
  assign alg_in[1] = light_mapper_two_alg;
  assign alg_in[2] = light_mapper_three_alg;

  for (genvar m = 0; m < 3; m++)
  begin : g_map
    azb_trend_t trend_r;
    azb_trend_t trend_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic armed_r;
    logic armed_nxt;
    logic [2:0] tgt_nxt;
    logic [1:0] alg_r;
    wire [2:0] zn = period_zone;
    wire up_step = zn > zone_r;
    wire dn_step = zn < zone_r;
    wire up_only = (alg_in[m] == AZB_UP_ONLY);
    wire [5:0] need_dn = fall_need(alg_in[m], hold_code);
    wire alg_chg = (alg_r != alg_in[m]);

    always_comb
    begin
      trend_nxt = trend_r;
      cnt_nxt = cnt_r;
      armed_nxt = 1'b0;
      tgt_nxt = tgt_r[m];
      if (armed_r && trend_r == AZB_TR_UP && up_step)
      begin
        tgt_nxt = zn;
        armed_nxt = 1'b1;
      end
      else if (armed_r && trend_r == AZB_TR_DOWN && dn_step && !up_only)
      begin
        tgt_nxt = zn;
        armed_nxt = 1'b1;
      end
      else if (zn > tgt_r[m])
      begin
        // Counting upward; a rise also drops any pending fall
        if (trend_r == AZB_TR_UP && !dn_step)
        begin
          cnt_nxt = cnt_inc(cnt_r);
        end
        else
        begin
          cnt_nxt = 6'h01;
        end
        trend_nxt = AZB_TR_UP;
        if (cnt_nxt >= `AZB_BASE_PERIODS)
        begin
          tgt_nxt = zn;
          armed_nxt = 1'b1;
          cnt_nxt = 6'h00;
        end
      end
      else if (zn < tgt_r[m])
      begin
        if (trend_r == AZB_TR_DOWN && !up_step)
        begin
          cnt_nxt = cnt_inc(cnt_r);
        end
        else
        begin
          cnt_nxt = 6'h01;
        end
        trend_nxt = AZB_TR_DOWN;
        if (!up_only && cnt_nxt >= need_dn)
        begin
          tgt_nxt = zn;
          armed_nxt = 1'b1;
          cnt_nxt = 6'h00;
        end
      end
      else
      begin
        trend_nxt = AZB_TR_IDLE;
        cnt_nxt = 6'h00;
      end
    end

    always_ff @(posedge mclk)
    begin
      if (sys_rst || !als_en || alg_chg)
      begin
        trend_r <= AZB_TR_IDLE;
        cnt_r <= 6'h00;
        armed_r <= 1'b0;
        alg_r <= alg_in[m];
      end
      else if (tk.tick)
      begin
        trend_r <= trend_nxt;
        cnt_r <= cnt_nxt;
        armed_r <= armed_nxt;
      end
    end

    always_ff @(posedge mclk)
    begin
      if (sys_rst || !als_en)
      begin
        tgt_r[m] <= `AZB_ZONE0;
        upd_r[m] <= 1'b0;
      end
      else
      begin
        upd_r[m] <= tk.tick && !alg_chg && (tgt_nxt != tgt_r[m]);
        if (tk.tick && !alg_chg)
        begin
          tgt_r[m] <= tgt_nxt;
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign light_fall_hold_count = hold_r;
  assign period_tick = tick_d_r;
  assign fast_avg = fast_d_r;
  assign avg_zone = zone_r;
  assign light_mapper_one_zone = tgt_r[0];
  assign light_mapper_two_zone = tgt_r[1];
  assign light_mapper_three_zone = tgt_r[2];
  assign target_upd = {upd_r[2], upd_r[1], upd_r[0]};

endmodule

// >>> test/azb_avg_model.sv
`timescale 1ns/1ps

module azb_avg_model
(
  // Clock
  input logic mclk,
  // Zones
  input logic [2:0] zone_in,
  output logic [2:0] period_zone
);
  // Zone of the averaging period now running
  always_ff @(posedge mclk)
  begin
    period_zone <= zone_in;
  end
endmodule

// >>> test/azb_zone_filter_chk.sv
`timescale 1ns/1ps

module azb_chk
  import azb_pkg::*;
(
  // Watched ports
  input logic mclk,
  input logic sys_rst,
  input logic als_en,
  input logic [1:0] light_mapper_two_alg,
  input logic [2:0] period_zone,
  input logic period_tick,
  input logic fast_avg,
  input logic [2:0] avg_zone,
  input logic [2:0] light_mapper_one_zone,
  input logic [2:0] light_mapper_two_zone,
  input logic [2:0] target_upd
);
  // ----
  // Checks
  // ----
  logic [1:0] n_tk_r;
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !als_en)
      n_tk_r <= 2'h0;
    else if (period_tick && n_tk_r != 2'h3)
      n_tk_r <= n_tk_r + 2'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  tick_gap_a: assert property (period_tick |=> !period_tick [*3])
    else $error("tick gap");
  upd_on_tick_a: assert property (|target_upd |-> period_tick)
    else $error("update off tick");
  zone_hold_a: assert property (!period_tick && $past(als_en)
    |-> $stable({light_mapper_one_zone, light_mapper_two_zone}))
    else $error("target moved mid period");
  upd_flag_a: assert property (period_tick |-> target_upd[0]
    == (light_mapper_one_zone != $past(light_mapper_one_zone)))
    else $error("update flag wrong");
  up_only_a: assert property (light_mapper_two_alg == AZB_UP_ONLY && $past(als_en)
    && $past(light_mapper_two_alg) == AZB_UP_ONLY
    |-> light_mapper_two_zone >= $past(light_mapper_two_zone))
    else $error("up-only target fell");
  fast_early_a: assert property (period_tick && n_tk_r < 2'h2 |-> fast_avg)
    else $error("fast period missing");
  fast_end_a: assert property (period_tick && n_tk_r == 2'h3 |-> !fast_avg)
    else $error("fast period too long");
  zone_init_a: assert property ($rose(als_en)
    |=> avg_zone == 3'h0 && light_mapper_one_zone == 3'h0)
    else $error("zone not zero at start");
  avg_follow_a: assert property (period_tick |-> avg_zone == $past(period_zone))
    else $error("avg zone wrong");
  off_clear_a: assert property (!als_en
    |=> target_upd == 3'h0 && light_mapper_two_zone == 3'h0)
    else $error("not cleared");
  cover property (period_tick && fast_avg);
  cover property (target_upd[2]);
  cover property ($fell(als_en));
endmodule

bind azb_zone_filter azb_chk u_chk
(
  .mclk(mclk),
  .sys_rst(sys_rst),
  .als_en(als_en),
  .light_mapper_two_alg(light_mapper_two_alg),
  .period_zone(period_zone),
  .period_tick(period_tick),
  .fast_avg(fast_avg),
  .avg_zone(avg_zone),
  .light_mapper_one_zone(light_mapper_one_zone),
  .light_mapper_two_zone(light_mapper_two_zone),
  .target_upd(target_upd)
);

// >>> test/tb_als_zone_brightness_filter.sv
`timescale 1ns/1ps

`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("BAD %0t %h %h", $time, (a), (b)); \
    end \
  end

module tb_als_zone_brightness_filter;
  import azb_pkg::*;
  // ----
  // Bench
  // ----
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic als_en = 1'b0;
  logic hold_wr = 1'b0;
  logic [7:0] hold_wdata = 8'h00;
  logic [1:0] light_mapper_one_alg = AZB_DIRECT;
  logic [1:0] light_mapper_two_alg = AZB_UP_ONLY;
  logic [1:0] light_mapper_three_alg = AZB_DOWN_DELAY;
  logic [2:0] zone_in = 3'h5;
  logic [7:0] light_fall_hold_count;
  logic period_tick, fast_avg;
  logic [2:0] period_zone, avg_zone, target_upd;
  logic [2:0] light_mapper_one_zone, light_mapper_two_zone, light_mapper_three_zone;
  logic [11:0] ex, prev;
  logic [2:0] exu;
  wire [11:0] zones = {avg_zone, light_mapper_one_zone, light_mapper_two_zone,
    light_mapper_three_zone};
  int miscompares = 0;
  int n_compared = 0;
  int i, k;
  // Zone in, then direct, up-only, down-delay targets
  logic [15:0] rows [20] = '{16'h5000, 16'h5000, 16'h5555, 16'h6666, 16'h6666,
    16'h4666, 16'h4666, 16'h4466, 16'h4466, 16'h4466, 16'h4464, 16'h4464,
    16'h2464, 16'h2464, 16'h5464, 16'h5464, 16'h5565, 16'h7767, 16'h7767, 16'h7777};

  always #4 mclk = ~mclk;

  azb_zone_filter #(.FAST_CYC(4), .NORM_CYC(8)) uut
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .als_en(als_en),
    .light_mapper_one_alg(light_mapper_one_alg),
    .light_mapper_two_alg(light_mapper_two_alg),
    .light_mapper_three_alg(light_mapper_three_alg),
    .hold_wr(hold_wr),
    .hold_wdata(hold_wdata),
    .light_fall_hold_count(light_fall_hold_count),
    .period_zone(period_zone),
    .period_tick(period_tick),
    .fast_avg(fast_avg),
    .avg_zone(avg_zone),
    .light_mapper_one_zone(light_mapper_one_zone),
    .light_mapper_two_zone(light_mapper_two_zone),
    .light_mapper_three_zone(light_mapper_three_zone),
    .target_upd(target_upd)
  );
  azb_avg_model u_avg
  (
    .mclk(mclk),
    .zone_in(zone_in),
    .period_zone(period_zone)
  );

  task automatic summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick;
    int n;
    n = 0;
    @(negedge mclk);
    while (period_tick !== 1'b1)
    begin
      n++;
      if (n > 40)
      begin
        miscompares++;
        summarize;
      end
      @(negedge mclk);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge mclk);
    hold_wr <= 1'b1;
    hold_wdata <= d;
    @(posedge mclk);
    hold_wr <= 1'b0;
    @(negedge mclk);
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    `CHK({light_fall_hold_count, avg_zone, target_upd, period_tick}, 15'h0)
    wr(8'hFF);
    `CHK(light_fall_hold_count, 8'hFF)
    wr(8'h00);
    `CHK(light_fall_hold_count, 8'h00)
    $display("test reset_reg done");
    @(posedge mclk);
    als_en <= 1'b1;
    prev = 12'h0;
    for (i = 0; i < 20; i++)
    begin
      tick;
      ex = {rows[i][14:12], rows[i][10:8], rows[i][6:4], rows[i][2:0]};
      `CHK(zones, ex)
      exu = {ex[2:0] != prev[2:0], ex[5:3] != prev[5:3], ex[8:6] != prev[8:6]};
      `CHK(target_upd, exu)
      prev = ex;
      @(posedge mclk);
      if (i < 19)
        zone_in <= rows[i + 1][14:12];
    end
    $display("test table done");
    @(posedge mclk);
    als_en <= 1'b0;
    zone_in <= 3'h3;
    wr(8'h02);
    `CHK({light_mapper_one_zone, light_mapper_three_zone, target_upd}, 9'h0)
    `CHK(light_fall_hold_count, 8'h02)
    @(posedge mclk);
    als_en <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK({fast_avg, avg_zone}, 4'h8)
    for (k = 1; k < 12; k++)
    begin
      tick;
      `CHK(light_mapper_one_zone, (k < 3) ? 3'h0 : (k < 6) ? 3'h3 : 3'h1)
      `CHK(light_mapper_three_zone, (k < 3) ? 3'h0 : (k < 11) ? 3'h3 : 3'h1)
      @(posedge mclk);
      zone_in <= (k < 3) ? 3'h3 : 3'h1;
    end
    $display("test down_delay done");
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK({light_fall_hold_count, fast_avg, avg_zone, target_upd, light_mapper_three_zone}, 18'h0)
    @(posedge mclk);
    sys_rst <= 1'b0;
    for (k = 1; k < 6; k++)
    begin
      tick;
      `CHK({fast_avg, avg_zone}, {k < 3, 3'h1})
      ex = {3'h0, (k < 3) ? 3'h0 : 3'h1, (k < 5) ? 3'h0 : 3'h1, k == 5, k == 3, k == 3};
      `CHK({light_mapper_one_zone, light_mapper_three_zone, target_upd}, ex[8:0])
      @(posedge mclk);
      if (k == 2)
        light_mapper_three_alg <= 2'h3;
    end
    $display("test rst_alg done");
    summarize;
  end
endmodule
